// ==== hw/lip_out_cell.sv ====
// one open-drain output: low time from level and blink phase, master gating
// assumes: sub/slot come from lip_timebase
`timescale 1ns/1ps
module lip_out_cell (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       run,
   input  wire logic [3:0] level,
   input  wire logic [3:0] master,
   input  wire logic       phase_bit,
   input  wire logic       blink_en,
   input  wire logic [3:0] sub,
   input  wire logic [3:0] slot,
   output logic            pin_oe_r
);
   logic [4:0] low_len;
   logic       active;
   logic       want_low;

   always_comb begin
      // phase 1 under blink mirrors the low time
      if (blink_en && phase_bit)
         low_len = {1'b0, lip_pkg::SLOT_LAST} - {1'b0, level};
      else
         low_len = {1'b0, level} + 5'h01;
      active   = slot < master;
      if (level == lip_pkg::LEVEL_STATIC)
         want_low = !(blink_en && phase_bit);
      else if (!run)
         want_low = 1'b0;
      else
         want_low = active && ({1'b0, sub} < low_len);
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         pin_oe_r <= 1'b0;
      else if (ce)
         pin_oe_r <= want_low;
   end
endmodule

// ==== hw/lip_pkg.sv ====
// package for the led intensity and blink pwm block
// assumes: one 100 MHz clock domain, register access by address/data strobes
package lip_pkg;
   localparam int          NUM_OUT        = 17;
   localparam logic [7:0]  MAL_OFFSET     = 8'h0E;
   localparam logic [7:0]  MAL_RESET      = 8'h0F;
   localparam int          MASTER_MSB     = 7;
   localparam int          MASTER_LSB     = 4;
   localparam int          AUX_MSB        = 3;
   localparam int          AUX_LSB        = 0;
   localparam int          AUX_INDEX      = 16;
   localparam logic [3:0]  LEVEL_STATIC   = 4'hF;
   localparam logic [3:0]  MASTER_SLOTS   = 4'hF;
   localparam logic [3:0]  LEVEL_HALF     = 4'h7;
   localparam logic [3:0]  SLOT_LAST      = 4'hF;
   localparam int          TICK_NS        = 1000;
   localparam int          CLK_NS         = 10;
   localparam int          TICK_CYCLES    = TICK_NS / CLK_NS;
   localparam logic [7:0]  TICK_LAST      = 8'(TICK_CYCLES - 1);
endpackage

// ==== hw/lip_timebase.sv ====
// pwm timebase: prescaler, 16 subslots per master slot, 15 master slots
// assumes: run low stops the oscillator and clears the counters
`timescale 1ns/1ps
module lip_timebase (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       run,
   output logic [3:0]      sub_r,
   output logic [3:0]      slot_r,
   output logic            tick_r,
   output logic            period_end_r
);
   logic [7:0] pre_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pre_r        <= 8'h00;
         sub_r        <= 4'h0;
         slot_r       <= 4'h0;
         tick_r       <= 1'b0;
         period_end_r <= 1'b0;
      end else if (ce) begin
         tick_r       <= 1'b0;
         period_end_r <= 1'b0;
         if (!run) begin
            pre_r  <= 8'h00;
            sub_r  <= 4'h0;
            slot_r <= 4'h0;
         end else if (pre_r == lip_pkg::TICK_LAST) begin
            pre_r  <= 8'h00;
            tick_r <= 1'b1;
            sub_r  <= sub_r + 4'h1;
            if (sub_r == lip_pkg::SLOT_LAST) begin
               if (slot_r == lip_pkg::MASTER_SLOTS - 4'h1) begin
                  slot_r       <= 4'h0;
               end else begin
                  slot_r <= slot_r + 4'h1;
               end
            end
         end else begin
            pre_r <= pre_r + 8'h01;
            // flags the last cycle, so new settings land with the wrap
            if (pre_r == lip_pkg::TICK_LAST - 8'h01 && sub_r == lip_pkg::SLOT_LAST &&
                slot_r == lip_pkg::MASTER_SLOTS - 4'h1)
               period_end_r <= 1'b1;
         end
      end
   end
endmodule

// ==== hw/lip_top.sv ====
// led intensity and blink pwm: master/aux level register and 17 outputs
// assumes: registers at byte offsets on a simple strobe port; per-output
// levels, blink enable and phase bits arrive as plain inputs
//
// How it works
// - 8-bit register, master level in upper nibble, aux level lower.
// - reading the register returns both nibbles unchanged.
// - master level zero stops oscillator, outputs static without pwm.
// - master code n gives duty of n fifteenths; 15 is full drive.
// - aux code n below 15 gives duty of n+1 sixteenths.
// - aux code 15 makes that output static.
// - blink phase 0 low n+1 sixteenths, phase 1 low 15-n sixteenths.
// - level 15 static low in phase 0, high impedance in phase 1.
// - level 7 gives equal low and high in both phases.
// - low levels dim then bright across phases, high levels the reverse.
// - global flag makes aux nibble the level for every output.
// - global mode: master and shared nibble give a 240-step control.
`timescale 1ns/1ps
module lip_top (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  wire logic [7:0]    reg_addr,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          global_en,
   input  wire logic          blink_en,
   input  wire logic [16:0]   phase_bits,
   input  wire logic [67:0]   levels,
   output logic [7:0]         reg_rdata_r,
   output logic               reg_hit_r,
   output logic [16:0]        pin_oe_r,
   output logic [16:0]        pin_o_r,
   output logic               osc_run_r
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  mal_r;
   logic [3:0]  master_act_r;
   logic [3:0]  lvl_act_r [lip_pkg::NUM_OUT];
   logic [3:0]  sub;
   logic [3:0]  slot;
   logic        period_end;
   logic [16:0] oe;

   function automatic logic [3:0] pick_level(input logic [67:0] lv, input logic [7:0] mal,
                                             input logic g, input int idx);
      if (g)
         pick_level = mal[lip_pkg::AUX_MSB:lip_pkg::AUX_LSB];
      else if (idx == lip_pkg::AUX_INDEX)
         pick_level = mal[lip_pkg::AUX_MSB:lip_pkg::AUX_LSB];
      else
         pick_level = lv[idx*4 +: 4];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register port
   always_ff @(posedge clk) begin
      if (!rst_n)
         mal_r <= lip_pkg::MAL_RESET;
      else if (ce && reg_wr && reg_addr == lip_pkg::MAL_OFFSET)
         mal_r <= reg_wdata;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata_r <= 8'h00;
         reg_hit_r   <= 1'b0;
      end else if (ce) begin
         reg_hit_r <= reg_rd && reg_addr == lip_pkg::MAL_OFFSET;
         if (reg_rd && reg_addr == lip_pkg::MAL_OFFSET)
            reg_rdata_r <= mal_r;
         else if (reg_rd)
            reg_rdata_r <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // active settings: loaded at period end, or at once while stopped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         master_act_r <= 4'h0;
         osc_run_r    <= 1'b0;
         for (int i = 0; i < lip_pkg::NUM_OUT; i++)
            lvl_act_r[i] <= lip_pkg::LEVEL_STATIC;
      end else if (ce && (period_end || !osc_run_r)) begin
         master_act_r <= mal_r[lip_pkg::MASTER_MSB:lip_pkg::MASTER_LSB];
         osc_run_r    <= mal_r[lip_pkg::MASTER_MSB:lip_pkg::MASTER_LSB] != 4'h0;
         for (int i = 0; i < lip_pkg::NUM_OUT; i++)
            lvl_act_r[i] <= pick_level(levels, mal_r, global_en, i);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   lip_timebase u_tb (
      .clk          (clk),
      .rst_n        (rst_n),
      .ce           (ce),
      .run          (osc_run_r),
      .sub_r        (sub),
      .slot_r       (slot),
      .tick_r       (),
      .period_end_r (period_end)
   );

   for (genvar g = 0; g < lip_pkg::NUM_OUT; g++) begin : g_out
      lip_out_cell u_cell (
         .clk       (clk),
         .rst_n     (rst_n),
         .ce        (ce),
         .run       (osc_run_r),
         .level     (lvl_act_r[g]),
         .master    (master_act_r),
         .phase_bit (phase_bits[g]),
         .blink_en  (blink_en),
         .sub       (sub),
         .slot      (slot),
         .pin_oe_r  (oe[g])
      );
   end

   // open drain: output value is always low, enable drives it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_oe_r <= 17'h00000;
         pin_o_r  <= 17'h00000;
      end else if (ce) begin
         pin_oe_r <= oe;
         pin_o_r  <= 17'h00000;
      end
   end
endmodule

// ==== test/lip_chk.sv ====
// checker for lip_top: register port, oscillator flag, open-drain data
// assumes: bound into lip_top, single clock domain
`timescale 1ns/1ps
module lip_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        ce,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata_r,
   input wire logic        reg_hit_r,
   input wire logic [16:0] pin_o_r,
   input wire logic        osc_run_r
);
   logic [7:0] sh_r;
   logic [3:0] mst;
   logic       rd_any, rd_hit;
   assign rd_any = ce && reg_rd;
   assign rd_hit = rd_any && reg_addr == lip_pkg::MAL_OFFSET;
   assign mst = sh_r[7:4];
   // shadow copy of the level register
   always_ff @(posedge clk) begin
      if (!rst_n) sh_r <= lip_pkg::MAL_RESET;
      else if (ce && reg_wr && reg_addr == lip_pkg::MAL_OFFSET) sh_r <= reg_wdata;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_hit_read: assert property (rd_hit |=> reg_hit_r)
      else $error("no hit after read");
   a_miss_read: assert property (rd_any && !rd_hit |=> !reg_hit_r && !(|reg_rdata_r))
      else $error("unmapped read answered");
   a_read_back: assert property (rd_hit |=> reg_rdata_r == $past(sh_r))
      else $error("read data differs");
   a_hit_cause: assert property (reg_hit_r |-> $past(rd_hit))
      else $error("hit without read");
   a_rdata_hold: assert property (!$past(rd_any) |-> $stable(reg_rdata_r))
      else $error("read data moved");
   a_osc_stop: assert property (mst == 4'h0 && !osc_run_r |=> !osc_run_r)
      else $error("oscillator runs at level 0");
   a_osc_run: assert property (mst != 4'h0 && $past(mst) != 4'h0 |-> osc_run_r)
      else $error("oscillator stopped");
   a_odrain_low: assert property (pin_o_r == 17'h0)
      else $error("pin driven high");
   c_read: cover property (rd_hit);
   c_miss: cover property (rd_any && !rd_hit);
   c_run: cover property (osc_run_r);
endmodule
bind lip_top lip_chk u_chk (.clk, .rst_n, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
                            .reg_rdata_r, .reg_hit_r, .pin_o_r, .osc_run_r);

// ==== test/lip_led_model.sv ====
// led loads with pull-ups on the open-drain pins, low-time counters
// assumes: pin_oe high sinks the line
`timescale 1ns/1ps
module lip_led_model (
   input  wire logic        clk,
   input  wire logic        clr,
   input  wire logic [16:0] pin_oe,
   input  wire logic [16:0] pin_o,
   output int               low_cnt [17]
);
   logic [16:0] line;
   // released pins float to the pull-up
   assign line = ~pin_oe | pin_o;
   always_ff @(posedge clk) begin
      for (int i = 0; i < 17; i++) low_cnt[i] <= clr ? 0 : low_cnt[i] + int'(line[i] === 1'b0);
   end
endmodule

// ==== test/tb.sv ====
// bench for lip_top: table of pwm set-ups, then reset and register cases
// assumes: lip_led_model counts low cycles of every pin
`timescale 1ns/1ps
module tb;
   typedef struct packed {logic [3:0] m; logic [3:0] a; logic ph; logic bl; logic gl;} lip_row_t;
   logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, clr = 1'b0;
   logic        global_en = 1'b0, blink_en = 1'b0, reg_hit_r, osc_run_r;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_r;
   logic [16:0] phase_bits = 17'h0, pin_oe_r, pin_o_r;
   logic [67:0] levels = {4'h0, 64'hFEDCBA9876543210};
   int          low_cnt [17], errors = 0, samples_checked = 0;
   lip_row_t    rows [5] = '{'{4'hF, 4'hF, 1'b0, 1'b1, 1'b0}, '{4'hF, 4'hE, 1'b1, 1'b1, 1'b0},
      '{4'hF, 4'h3, 1'b1, 1'b0, 1'b0}, '{4'h1, 4'h7, 1'b0, 1'b0, 1'b0},
      '{4'hF, 4'h3, 1'b0, 1'b0, 1'b1}};
   lip_top u_dut (.clk, .rst_n, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .global_en,
      .blink_en, .phase_bits, .levels, .reg_rdata_r, .reg_hit_r, .pin_oe_r, .pin_o_r, .osc_run_r);
   lip_led_model u_led (.clk, .clr, .pin_oe(pin_oe_r), .pin_o(pin_o_r), .low_cnt);
   ////////////////////////////////////////
   task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk_cnt(input int i, input int e);
      samples_checked++;
      if (low_cnt[i] !== e) begin
         errors++;
         $display("[FAIL] low_cnt[%0d] expected %0d seen %0d", i, e, low_cnt[i]);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk_val("rdata", e, reg_rdata_r);
      chk_val("hit", {7'h00, h}, {7'h00, reg_hit_r});
      @(posedge clk);
   endtask
   // clear counters, then count w cycles
   task automatic meas(input int w);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (w) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic end_sim();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      end_sim();
   end
   initial begin
      lip_row_t r;
      int w, n, e;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[k]) begin
         r = rows[k];
         // restart from reset so the new setting holds from the first period
         rst_n <= 1'b0;
         blink_en <= r.bl;
         phase_bits <= {17{r.ph}};
         global_en <= r.gl;
         repeat (2) @(posedge clk);
         rst_n <= 1'b1;
         wr(lip_pkg::MAL_OFFSET, {r.m, r.a});
         repeat (8) @(posedge clk);
         w = lip_pkg::TICK_CYCLES * ((r.m == 4'hF) ? 16 : 240);
         meas(w);
         for (int i = 0; i < 17; i++) begin
            n = (r.gl || i == 16) ? r.a : i;
            e = (r.bl && r.ph) ? 15 - n : n + 1;
            if (n == 15) e = (r.bl && r.ph) ? 0 : w;
            else e = e * lip_pkg::TICK_CYCLES * ((r.m == 4'hF) ? 1 : r.m);
            chk_cnt(i, e);
         end
         @(posedge clk);
      end
      // master zero mid-period: oscillator keeps running until the period ends
      wr(lip_pkg::MAL_OFFSET, 8'h03);
      @(negedge clk);
      chk_val("osc_hold", 8'h01, {7'h00, osc_run_r});
      @(posedge clk);
      rst_n <= 1'b0;
      blink_en <= 1'b0;
      global_en <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(lip_pkg::MAL_OFFSET, lip_pkg::MAL_RESET, 1'b1);
      meas(200);
      chk_val("osc_run", 8'h00, {7'h00, osc_run_r});
      for (int i = 0; i < 17; i++) chk_cnt(i, (i >= 15) ? 200 : 0);
      @(posedge clk);
      wr(8'h0F, 8'hA5);
      rd(8'h0F, 8'h00, 1'b0);
      rd(lip_pkg::MAL_OFFSET, lip_pkg::MAL_RESET, 1'b1);
      wr(lip_pkg::MAL_OFFSET, 8'h5A);
      rd(lip_pkg::MAL_OFFSET, 8'h5A, 1'b1);
      // write while frozen by the clock enable must not land
      ce <= 1'b0;
      wr(lip_pkg::MAL_OFFSET, 8'h33);
      ce <= 1'b1;
      rd(lip_pkg::MAL_OFFSET, 8'h5A, 1'b1);
      end_sim();
   end
endmodule
